// File: core/epv_pkg.sv
/*
 * Shared constants and carrier types for the non-volatile program and
 * verify sequencer: register offsets, widths, reset values and the
 * bundle of pin levels.
 * Assumes a 32-bit APB master and a 40 MHz pclk.
 */
package epv_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int unsigned SR_W    = 20;    // Shadow register and array width
  localparam int unsigned OPT_W   = 8;     // Option register width
  localparam int unsigned OPT_DOUT = 1;    // Option bit routing shadow to dout
  localparam int unsigned VERIFY_PULSES = 19; // Clock pulses to read 20 bits

  // ---------------------------------------------------------------
  // APB register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00; // Control, read/write
  localparam logic [7:0] SHADOW_OFS = 8'h04; // Shadow register, read only
  localparam logic [7:0] ARRAY_OFS  = 8'h08; // Non-volatile array, read only
  localparam logic [7:0] OPTION_OFS = 8'h0c; // Active option bits, read only
  localparam logic [7:0] STATUS_OFS = 8'h10; // Sequencer status, read only

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_PROG_EN = 0;  // Allow erase and write pulses
  localparam int unsigned STAT_FROM_NV = 0;  // Shadow holds array data
  localparam int unsigned STAT_ERASED  = 1;  // An erase ran since reset
  localparam int unsigned STAT_WRITTEN = 2;  // A write ran since reset
  localparam int unsigned STAT_DOUT_ON = 3;  // Shadow routed to dout
  localparam logic [0:0]       CTRL_RST   = 1'h1;
  localparam logic [SR_W-1:0]  SHADOW_RST = 20'h00000;
  localparam logic [SR_W-1:0]  ARRAY_RST  = 20'hfffff; // Erased state
  localparam logic [OPT_W-1:0] OPT_RST    = 8'h00;

  // ---------------------------------------------------------------
  // Carrier: external pin levels, all asynchronous to pclk
  // ---------------------------------------------------------------
  typedef struct packed {
    logic sclk;        // Serial clock from the programmer
    logic sdata;       // Serial data
    logic s_wr;        // Secondary write strobe
    logic nv_select;   // Non-volatile select
    logic nv_load;     // Non-volatile load
    logic opt_wr;      // Option register write strobe
    logic opt_en_n;    // Option mode enable, active low
    logic vpp_erase;   // Negative programming pulse present
    logic vpp_write;   // Positive programming pulse present
  } epv_pins_s;

  localparam epv_pins_s PINS_RST = '{default: 1'b0};

endpackage

// File: core/epv_sequencer.sv
/*
 * Program and verify sequencer for the 20-bit non-volatile word.
 * Holds the shadow register, the option register, the array model and
 * an APB slave for status and control.
 * Assumes all pin inputs are asynchronous to pclk and the serial clock
 * is much slower than pclk (at least four pclk periods per level).
 */
// Contract
// - Whole word programmed in one parallel step
// - Write ANDs array with shadow bits
// - Dout shows shadow bits during reload
// - Twenty bits read with nineteen pulses
// - Delayed nv_select rise copies array
// - Rising serial clock shifts LSB first
// - Option bits apply on strobe falling edge
// - Synthesizer uses only array-copied data
`timescale 1ns/10ps
module epv_sequencer (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      ce,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire epv_pkg::epv_pins_s        pins,
  output logic                           dout,
  output logic      [epv_pkg::SR_W-1:0]  freq_word,
  output logic                           freq_valid
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  epv_pkg::epv_pins_s            sync1_r;     // First synchroniser stage
  epv_pkg::epv_pins_s            sync2_r;     // Second stage, safe to use
  epv_pkg::epv_pins_s            prev_r;      // Previous safe sample
  logic [epv_pkg::SR_W-1:0]      shadow_r;    // Shadow register
  logic [epv_pkg::SR_W-1:0]      array_r;     // Non-volatile cells
  logic [epv_pkg::OPT_W-1:0]     opt_sh_r;    // Option shift stage
  logic [epv_pkg::OPT_W-1:0]     opt_r;       // Option buffer in effect
  logic [0:0]                    ctrl_r;      // Control register
  logic                          from_nv_r;   // Shadow came from array
  logic                          erased_r;    // Erase seen
  logic                          written_r;   // Write seen
  logic [epv_pkg::SR_W-1:0]      freq_r;      // Word to the synthesizer
  logic                          fvalid_r;    // Word is valid
  logic                          dout_r;      // Registered serial output
  logic                          sclk_rise;   // Serial clock rising edge
  logic                          erase_go;    // Erase pulse starts
  logic                          write_go;    // Write pulse starts
  logic                          nv_copy;     // Array to shadow copy
  logic                          dout_on;     // Shadow routed to dout
  logic                          sh_load;     // Serial load of shadow
  logic                          opt_load;    // Serial load of option
  logic                          apb_acc;     // APB access phase
  logic                          mapped;      // Address decodes

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Rising edge of a synchronised level
  function automatic logic rise(input logic now, input logic was);
    rise = now & ~was;
  endfunction

  // Falling edge of a synchronised level
  function automatic logic fall(input logic now, input logic was);
    fall = ~now & was;
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Two stages before any logic reads a pin; a third for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= epv_pkg::PINS_RST;
      sync2_r <= epv_pkg::PINS_RST;
      prev_r  <= epv_pkg::PINS_RST;
    end else if (ce) begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // ---------------------------------------------------------------
  // Event decode
  // ---------------------------------------------------------------
  assign sclk_rise = rise(sync2_r.sclk, prev_r.sclk);
  // Option routes shadow out only while the option mode is enabled
  assign dout_on   = opt_r[epv_pkg::OPT_DOUT] & ~sync2_r.opt_en_n;
  // Erase level set: all three lines high, pulse begins
  assign erase_go  = ctrl_r[epv_pkg::CTRL_PROG_EN] & sync2_r.s_wr & sync2_r.nv_select
                     & sync2_r.nv_load & rise(sync2_r.vpp_erase, prev_r.vpp_erase);
  // Write level set: select low, strobe and load high
  assign write_go  = ctrl_r[epv_pkg::CTRL_PROG_EN] & sync2_r.s_wr & ~sync2_r.nv_select
                     & sync2_r.nv_load & rise(sync2_r.vpp_write, prev_r.vpp_write);
  // Copy on select rising with load low, or load falling with select high
  assign nv_copy   = (rise(sync2_r.nv_select, prev_r.nv_select) & ~sync2_r.nv_load)
                   | (fall(sync2_r.nv_load, prev_r.nv_load) & sync2_r.nv_select);
  // Shadow takes serial data with both strobes low and load high
  assign sh_load   = ~sync2_r.s_wr & ~sync2_r.opt_wr & sync2_r.nv_load;
  assign opt_load  = sync2_r.opt_wr;

  // ---------------------------------------------------------------
  // Shadow register
  // ---------------------------------------------------------------
  // Array copy wins over a shift in the same cycle; it is the parallel path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_r <= epv_pkg::SHADOW_RST;
    end else if (ce) begin
      if (nv_copy) begin
        shadow_r <= array_r;
      end else if (sclk_rise && (dout_on || sh_load)) begin
        // LSB leaves first, data enters at the top
        shadow_r <= {sync2_r.sdata, shadow_r[epv_pkg::SR_W-1:1]};
      end
    end
  end

  // Origin of the shadow contents
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      from_nv_r <= 1'b0;
    end else if (ce) begin
      if (nv_copy) begin
        from_nv_r <= 1'b1;
      end else if (sclk_rise && (dout_on || sh_load)) begin
        from_nv_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Non-volatile array
  // ---------------------------------------------------------------
  // Every bit changes in the same cycle; write can only clear bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      array_r <= epv_pkg::ARRAY_RST;
    end else if (ce) begin
      if (erase_go) begin
        array_r <= epv_pkg::ARRAY_RST;
      end else if (write_go) begin
        array_r <= array_r & shadow_r;
      end
    end
  end

  // Sticky history for software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erased_r  <= 1'b0;
      written_r <= 1'b0;
    end else if (ce) begin
      erased_r  <= erased_r | erase_go;
      written_r <= written_r | write_go;
    end
  end

  // ---------------------------------------------------------------
  // Option register
  // ---------------------------------------------------------------
  // Shift stage fills while the strobe is high, buffer on its fall;
  // buffering keeps routing steady while new bits stream in
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_sh_r <= epv_pkg::OPT_RST;
      opt_r    <= epv_pkg::OPT_RST;
    end else if (ce) begin
      if (opt_load && sclk_rise) begin
        opt_sh_r <= {sync2_r.sdata, opt_sh_r[epv_pkg::OPT_W-1:1]};
      end
      if (fall(sync2_r.opt_wr, prev_r.opt_wr)) begin
        opt_r <= opt_sh_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // Serial output and synthesizer word
  // ---------------------------------------------------------------
  // Bit 0 is visible before the first pulse, so 19 pulses read 20 bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_r <= 1'b0;
    end else if (ce) begin
      dout_r <= dout_on ? shadow_r[0] : 1'b0;
    end
  end

  // Only array-origin data reaches the synthesizer while selected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_r   <= epv_pkg::SHADOW_RST;
      fvalid_r <= 1'b0;
    end else if (ce) begin
      if (sync2_r.nv_select && !sync2_r.nv_load && from_nv_r) begin
        freq_r   <= shadow_r;
        fvalid_r <= 1'b1;
      end else if (!sync2_r.nv_select) begin
        fvalid_r <= 1'b0;
      end
    end
  end

  assign dout       = dout_r;
  assign freq_word  = freq_r;
  assign freq_valid = fvalid_r;

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  assign apb_acc = psel & penable;
  assign mapped  = (paddr == epv_pkg::CTRL_OFS) | (paddr == epv_pkg::SHADOW_OFS)
                 | (paddr == epv_pkg::ARRAY_OFS) | (paddr == epv_pkg::OPTION_OFS)
                 | (paddr == epv_pkg::STATUS_OFS);
  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = apb_acc & ~mapped;

  // Control writes; only the programming enable is writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= epv_pkg::CTRL_RST;
    end else if (ce && apb_acc && pwrite && paddr == epv_pkg::CTRL_OFS) begin
      ctrl_r <= pwdata[epv_pkg::CTRL_PROG_EN +: 1];
    end
  end

  // Read data registered in the setup cycle so it is stable at access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (ce && psel && !penable && !pwrite) begin
      case (paddr)
        epv_pkg::CTRL_OFS:   prdata <= {31'h00000000, ctrl_r};
        epv_pkg::SHADOW_OFS: prdata <= {12'h000, shadow_r};
        epv_pkg::ARRAY_OFS:  prdata <= {12'h000, array_r};
        epv_pkg::OPTION_OFS: prdata <= {24'h000000, opt_r};
        epv_pkg::STATUS_OFS: prdata <= {28'h0000000, dout_on, written_r, erased_r, from_nv_r};
        default:             prdata <= 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence erase_req_s;
    ce && erase_go;
  endsequence
  sequence write_req_s;
    ce && write_go && !erase_go;
  endsequence

  erase_fill_a: assert property (erase_req_s |=> array_r == epv_pkg::ARRAY_RST)
    else $error("erase did not set every cell");
  write_and_a: assert property (write_req_s |=> array_r == ($past(array_r) & $past(shadow_r)))
    else $error("write result is not the AND of array and shadow");
  write_gate_a: assert property (ce && !erase_go && !write_go |=> array_r == $past(array_r))
    else $error("array changed without a programming pulse");
  nv_copy_a: assert property (ce && nv_copy |=> shadow_r == $past(array_r) && from_nv_r)
    else $error("array copy did not reach the shadow register");
  shift_lsb_a: assert property (ce && sclk_rise && dout_on && !nv_copy
      |=> shadow_r[epv_pkg::SR_W-2:0] == $past(shadow_r[epv_pkg::SR_W-1:1]))
    else $error("shadow did not shift toward the output");
  dout_lsb_a: assert property (ce && dout_on |=> dout == $past(shadow_r[0]))
    else $error("dout does not show the shadow LSB");
  opt_fall_a: assert property (ce && !fall(sync2_r.opt_wr, prev_r.opt_wr)
      |=> opt_r == $past(opt_r))
    else $error("option buffer changed outside strobe fall");
  freq_src_a: assert property (ce && fvalid_r && !$past(fvalid_r) |-> $past(from_nv_r))
    else $error("synthesizer word taken from serial data");
  apb_err_a: assert property (psel && penable && !mapped |-> pslverr && pready) // Bus refusal
    else $error("unmapped access not refused");

endmodule // epv_sequencer

// File: verification/epv_programmer.sv
/*
 * Programmer model: drives the sequencer pins, shifts words in, pulses
 * the programming supply and reads dout back.
 * Assumes every caller enters a task right after a pclk rising edge.
 */
`timescale 1ns/10ps
module epv_programmer (
  input  logic               pclk, // Paces every pin change
  input  logic               dout, // Serial output of the block
  output epv_pkg::epv_pins_s pins  // Levels toward the block
);
  // ------------
  // Pin driving
  // ------------
  // Option mode held off until verify starts
  initial pins = '{opt_en_n: 1'b1, default: 1'b0};

  // Control levels, then settle well past the input sync
  task automatic set_lines(input logic wr, sel, ld, owr, oen_n);
    pins.s_wr      <= wr;
    pins.nv_select <= sel;
    pins.nv_load   <= ld;
    pins.opt_wr    <= owr;
    pins.opt_en_n  <= oen_n;
    repeat (8) @(posedge pclk);
  endtask

  // One bit, 200 ns period: 4 pclk low with data set, 4 pclk high;
  // sclk only moves inside a frame. Dout is taken one pclk into the
  // low half, well after the previous rise has settled it
  task automatic clk_bit(input logic b, output logic o);
    pins.sdata <= b;
    @(posedge pclk);
    o = dout;
    repeat (3) @(posedge pclk);
    pins.sclk <= 1'b1;
    repeat (4) @(posedge pclk);
    pins.sclk <= 1'b0;
  endtask

  // LSB first; data line left inverted so a stale level never helps
  task automatic shift(input logic [19:0] v, input int n);
    logic o; // Read-back not needed while loading
    for (int i = 0; i < n; i++) clk_bit(v[i], o);
    pins.sdata <= ~v[n-1];
  endtask

  // Lines already steady; pulse scaled down from 25 ms, gap from 100 ms
  task automatic pulse(input logic erase);
    if (erase) pins.vpp_erase <= 1'b1;
    else pins.vpp_write <= 1'b1;
    repeat (16) @(posedge pclk);
    pins.vpp_erase <= 1'b0;
    pins.vpp_write <= 1'b0;
    repeat (24) @(posedge pclk);
  endtask

  // Bit 0 already on dout, so 19 pulses give all 20 bits
  task automatic read_word(input logic [19:0] fill, output logic [19:0] w);
    logic o; // Dout level before each rise
    for (int i = 0; i < epv_pkg::VERIFY_PULSES; i++) begin
      clk_bit(fill[i], o);
      w[i] = o;
    end
    @(posedge pclk);
    w[epv_pkg::VERIFY_PULSES] = dout;
  endtask
endmodule // epv_programmer

// File: verification/testbench.sv
/*
 * Self-checking bench for the program and verify sequencer.
 * Assumes the programmer model and the sequencer share pclk.
 */
`timescale 1ns/10ps
module testbench;
  // ------------
  // Signals
  // ------------
  logic               pclk    = 1'b0;   // 40 MHz bus clock
  logic               presetn = 1'b0;   // Async reset, active low
  logic               ce      = 1'b1;   // Held high except during one control write
  logic               psel    = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite  = 1'b0;
  logic [7:0]         paddr   = 8'h00;
  logic [31:0]        pwdata  = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  epv_pkg::epv_pins_s pins;             // From the programmer model
  logic               dout;
  logic [19:0]        freq_word;
  logic               freq_valid;
  int                 miscompares     = 0;
  int                 samples_checked = 0;
  logic [19:0]        arr, w1, w2, w3, fill, got; // Expected array, words

  initial forever #12.5 pclk = ~pclk;

  epv_sequencer DUT (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .dout(dout),
    .freq_word(freq_word), .freq_valid(freq_valid));

  epv_programmer u_prog (.pclk(pclk), .dout(dout), .pins(pins));

  // ------------
  // Helpers
  // ------------
  // Verdict and end of run, from the main sequence or the watchdog
  task automatic stop_test();
    if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready seen high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) miscompares++;
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk); // Gap so psel never toggles twice in one step
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
    logic [31:0] q;
    logic        e;
    xfer(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk(32'(e), 32'(eerr));
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, a, d, q, e);
    chk(32'(e), 32'h0);
  endtask

  // Serial load path: s_wr low, option strobe low, nv_load high
  task automatic load(input logic [19:0] w);
    u_prog.set_lines(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    u_prog.shift(w, 20);
    rd_chk(epv_pkg::SHADOW_OFS, 32'(w), 1'b0);
  endtask

  // Erase levels all high; write levels drop nv_select only
  task automatic prog(input logic erase);
    u_prog.set_lines(1'b1, erase, 1'b1, 1'b0, 1'b1);
    u_prog.pulse(erase);
  endtask

  // Array after a pulse: erase sets every bit, write can only clear
  function automatic logic [19:0] nv_next(input logic [19:0] old, sh, input logic er);
    return er ? 20'hfffff : (old & sh);
  endfunction

  // ------------
  // Scenarios
  // ------------
  initial begin
    void'($urandom(49057));
    w1 = 20'($urandom);
    w2 = 20'($urandom);
    w3 = 20'($urandom) | 20'h00001; // Bit 0 set so routing shows on dout
    fill = 20'($urandom);
    arr = 20'hfffff;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(freq_valid), 32'h0);
    rd_chk(epv_pkg::CTRL_OFS, 32'h1, 1'b0);
    rd_chk(epv_pkg::STATUS_OFS, 32'h0, 1'b0);
    rd_chk(8'h14, 32'h0, 1'b1);
    wr(epv_pkg::ARRAY_OFS, 32'h0); // Read-only, must be ignored
    // Clock enable low: the control write must not land
    ce <= 1'b0;
    wr(epv_pkg::CTRL_OFS, 32'h0);
    ce <= 1'b1;
    rd_chk(epv_pkg::CTRL_OFS, 32'h1, 1'b0);
    // Two writes with no erase between: bits only clear
    for (int k = 0; k < 2; k++) begin
      load(k == 0 ? w1 : w2);
      prog(1'b0);
      arr = nv_next(arr, k == 0 ? w1 : w2, 1'b0);
      rd_chk(epv_pkg::ARRAY_OFS, 32'(arr), 1'b0);
    end
    // Locked programming, then wrong levels: both ignored
    load(w3);
    wr(epv_pkg::CTRL_OFS, 32'h0);
    prog(1'b0);
    wr(epv_pkg::CTRL_OFS, 32'h1);
    u_prog.set_lines(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    u_prog.pulse(1'b0);
    rd_chk(epv_pkg::ARRAY_OFS, 32'(arr), 1'b0);
    rd_chk(epv_pkg::SHADOW_OFS, 32'(w3), 1'b0);
    prog(1'b1);
    arr = nv_next(arr, w3, 1'b1);
    rd_chk(epv_pkg::ARRAY_OFS, 32'(arr), 1'b0);
    prog(1'b0);
    arr = nv_next(arr, w3, 1'b0);
    rd_chk(epv_pkg::ARRAY_OFS, 32'(arr), 1'b0);
    u_prog.set_lines(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    // Verify: option bit 1, applied only when the strobe falls
    u_prog.set_lines(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    u_prog.shift(20'h00002, 8);
    rd_chk(epv_pkg::OPTION_OFS, 32'h0, 1'b0);
    u_prog.set_lines(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    rd_chk(epv_pkg::OPTION_OFS, 32'h2, 1'b0);
    chk(32'(dout), 32'h0);
    u_prog.set_lines(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(32'(dout), 32'h1);
    // First pass: reload on nv_select rise, output discarded
    u_prog.set_lines(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    u_prog.read_word(fill, got);
    rd_chk(epv_pkg::SHADOW_OFS, 32'({fill[18:0], arr[19]}), 1'b0);
    // Second pass: reload on nv_load fall, stored word read back
    u_prog.set_lines(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    u_prog.set_lines(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    rd_chk(epv_pkg::STATUS_OFS, 32'hf, 1'b0);
    chk(32'(freq_valid), 32'h1);
    chk(32'(freq_word), 32'(arr));
    u_prog.read_word(fill, got);
    chk(32'(got), 32'(arr));
    u_prog.set_lines(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(32'(freq_valid), 32'h0);
    // Mid-run reset: array back to erased, history cleared
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(epv_pkg::ARRAY_OFS, 32'h000fffff, 1'b0);
    rd_chk(epv_pkg::STATUS_OFS, 32'h0, 1'b0);
    chk(32'(dout), 32'h0);
    stop_test();
  end

  // Watchdog: run needs a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    stop_test();
  end
endmodule // testbench
